/* core/dev_ctl_stat.sv */
// Purpose: device control (0xE8) and device status (0xEA) registers
// Assumes: cfg requests and event inputs are synchronous to clk
// Notes:   aux-power strap has its own power-good reset and a two-flop sync
module dev_ctl_stat
    import devctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        pwr_good_rst,
    input  wire cfg_req_t    cfg_req,
    output logic [31:0]      cfg_rdata,
    input  wire err_evt_t    err_evt,
    input  wire logic        aux_pwr_strap,
    input  wire logic [7:0]  np_outstanding,
    input  wire logic        no_snoop_gate_bits,
    input  wire logic        relaxed_order_disable,
    input  wire logic [12:0] rx_payload_len,
    input  wire logic        rx_payload_chk,
    output logic             rx_payload_err,
    output tl_cfg_t          tl_cfg,
    output logic [12:0]      tx_payload_max,
    output logic [12:0]      rd_req_max
);

    logic [15:0] ctrl_q;
    logic [3:0]  err_q;
    logic        aux_s1_q;
    logic        aux_s2_q;
    logic        pend_q;
    logic        hit;
    logic [15:0] ctrl_wr;
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;
    logic [3:0]  w1c;

    assign hit = (cfg_req.addr == DEV_CTRL_OFS);

    // byte-lane merge of a control write; read-only bits keep their value
    always_comb begin
        ctrl_wr = ctrl_q;
        if (cfg_req.be[0]) begin
            ctrl_wr[7:0] = cfg_req.wdata[7:0];
        end
        if (cfg_req.be[1]) begin
            ctrl_wr[15:8] = cfg_req.wdata[15:8];
        end
        ctrl_wr = (ctrl_wr & CTRL_WR_MASK) | (ctrl_q & ~CTRL_WR_MASK);
    end

    // control register, writable fields only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (cfg_req.wr && hit) begin
            ctrl_q <= ctrl_wr;
        end
    end

    property p_ctrl_lo_wr;
        @(posedge clk) disable iff (sys_rst)
            cfg_req.wr && hit && cfg_req.be[0] |=> ctrl_q[7:0] == $past(cfg_req.wdata[7:0]);
    endproperty
    a_ctrl_lo_wr: assert property (p_ctrl_lo_wr) else $error("low byte lost");

    property p_ctrl_hi_wr;
        @(posedge clk) disable iff (sys_rst)
            cfg_req.wr && hit && cfg_req.be[1]
                |=> ctrl_q[14:11] == $past(cfg_req.wdata[14:11])
                    && ctrl_q[9:8] == $past(cfg_req.wdata[9:8]);
    endproperty
    a_ctrl_hi_wr: assert property (p_ctrl_hi_wr) else $error("high byte lost");

    property p_ctrl_ro_bits;
        @(posedge clk) disable iff (sys_rst)
            !ctrl_q[10] && !ctrl_q[15];
    endproperty
    a_ctrl_ro_bits: assert property (p_ctrl_ro_bits) else $error("ro bit set");

    property p_ctrl_hold;
        @(posedge clk) disable iff (sys_rst)
            !(cfg_req.wr && hit) |=> ctrl_q == $past(ctrl_q);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl drifted");

    // write-one-to-clear mask from the status byte lane
    assign w1c = (cfg_req.wr && hit && cfg_req.be[2]) ? cfg_req.wdata[19:16] : 4'h0;

    // set wins over a same-cycle clear; enables do not gate detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            err_q <= STAT_ERR_RESET;
        end else begin
            err_q <= (err_q & ~w1c) | err_evt;
        end
    end

    property p_stat_hold;
        @(posedge clk) disable iff (sys_rst)
            !cfg_req.wr && (err_evt == '0) |=> err_q == $past(err_q);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("status drifted");

    property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
            err_evt.corr && w1c[0] |=> err_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_ur_w1c;
        @(posedge clk) disable iff (sys_rst)
            (w1c[3] && !err_evt.ur) |=> !err_q[3];
    endproperty
    a_ur_w1c: assert property (p_ur_w1c) else $error("ur not cleared");

    // strap sync; held over function reset, cleared only by power-good
    always_ff @(posedge clk) begin
        if (pwr_good_rst) begin
            aux_s1_q <= 1'b0;
            aux_s2_q <= 1'b0;
        end else begin
            aux_s1_q <= aux_pwr_strap;
            aux_s2_q <= aux_s1_q;
        end
    end

    // function reset must not disturb the strap pipeline
    property p_aux_keep;
        @(posedge clk) disable iff (pwr_good_rst)
            !pwr_good_rst |=> aux_s2_q == $past(aux_s1_q);
    endproperty
    a_aux_keep: assert property (p_aux_keep) else $error("aux flag lost");

    // pending flag registered to keep read data off a long comb path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= (np_outstanding != 8'h00);
        end
    end

    property p_pend_set;
        @(posedge clk) disable iff (sys_rst)
            (np_outstanding != 8'h00) |=> pend_q;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending late");

    property p_pend_clr;
        @(posedge clk) disable iff (sys_rst)
            (np_outstanding == 8'h00) |=> !pend_q;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending stuck");

    // reserved bits pinned to zero on the read side
    always_comb begin
        ctrl_rd = ctrl_q & CTRL_WR_MASK;
        stat_rd = 16'h0000;
        stat_rd[3:0] = err_q;
        stat_rd[STAT_AUX_BIT] = aux_s2_q;
        stat_rd[STAT_PEND_BIT] = pend_q;
    end

    // read data registered; unmapped dwords read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_req.rd) begin
            cfg_rdata <= hit ? {stat_rd, ctrl_rd} : 32'h0000_0000;
        end
    end

    property p_rd_ctrl;
        @(posedge clk) disable iff (sys_rst)
            cfg_req.rd && hit |=> cfg_rdata[15:0] == $past(ctrl_q);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl read wrong");

    property p_rd_err;
        @(posedge clk) disable iff (sys_rst)
            cfg_req.rd && hit |=> cfg_rdata[19:16] == $past(err_q);
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("status read wrong");

    // settings to the transaction layer; extended tag and phantom unused
    always_comb begin
        tl_cfg.err_report_en = ctrl_q[3:0];
        tl_cfg.relaxed_ok = ctrl_q[CTRL_RO_EN_BIT] & ~relaxed_order_disable;
        tl_cfg.no_snoop_ok = ctrl_q[CTRL_NS_EN_BIT] & no_snoop_gate_bits;
        tl_cfg.max_payload = ctrl_q[CTRL_MPS_LSB +: 3];
        tl_cfg.max_read_req = ctrl_q[CTRL_MRRS_LSB +: 3];
    end

    property p_ro_disable;
        @(posedge clk) disable iff (sys_rst)
            relaxed_order_disable |-> !tl_cfg.relaxed_ok;
    endproperty
    a_ro_disable: assert property (p_ro_disable) else $error("ro not disabled");

    // byte limits: 128 << code; payload clipped at the supported size, read request at 4096
    always_comb begin
        if (ctrl_q[CTRL_MPS_LSB +: 3] > MPS_SUPPORTED) begin
            tx_payload_max = 13'h0080 << MPS_SUPPORTED;
        end else begin
            tx_payload_max = 13'h0080 << ctrl_q[CTRL_MPS_LSB +: 3];
        end
        rd_req_max = (ctrl_q[CTRL_MRRS_LSB +: 3] > 3'h5) ? 13'h1000
                   : 13'h0080 << ctrl_q[CTRL_MRRS_LSB +: 3];
    end

    // any code past the supported one lands on 256 bytes
    property p_mps_map;
        @(posedge clk) disable iff (sys_rst)
            (ctrl_q[CTRL_MPS_LSB +: 3] == 3'h0) ? (tx_payload_max == 13'h0080)
                                               : (tx_payload_max == 13'h0100);
    endproperty
    a_mps_map: assert property (p_mps_map) else $error("payload limit wrong");

    property p_mrrs_dflt;
        @(posedge clk) disable iff (sys_rst)
            (ctrl_q[CTRL_MRRS_LSB +: 3] == 3'h2) |-> rd_req_max == 13'h0200;
    endproperty
    a_mrrs_dflt: assert property (p_mrrs_dflt) else $error("read limit wrong");

    // oversize check against the clipped size, the smaller of programmed and supported
    assign rx_payload_err = rx_payload_chk && (rx_payload_len > tx_payload_max);

    property p_rx_over;
        @(posedge clk) disable iff (sys_rst)
            rx_payload_chk && (rx_payload_len > tx_payload_max) |-> rx_payload_err;
    endproperty
    a_rx_over: assert property (p_rx_over) else $error("oversize not flagged");

    property p_ur_sets;
        @(posedge clk) disable iff (sys_rst) err_evt.ur |=> err_q[3];
    endproperty
    a_ur_sets: assert property (p_ur_sets) else $error("ur flag not set");

    property p_w1c;
        @(posedge clk) disable iff (sys_rst)
            (w1c[0] && !err_evt.corr) |=> !err_q[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c did not clear");

    property p_ro_gate;
        @(posedge clk) disable iff (sys_rst)
            tl_cfg.relaxed_ok |-> ctrl_q[CTRL_RO_EN_BIT];
    endproperty
    a_ro_gate: assert property (p_ro_gate) else $error("relaxed order leak");

    property p_ns_gate;
        @(posedge clk) disable iff (sys_rst)
            tl_cfg.no_snoop_ok |-> (ctrl_q[CTRL_NS_EN_BIT] && no_snoop_gate_bits);
    endproperty
    a_ns_gate: assert property (p_ns_gate) else $error("no-snoop leak");

    property p_rsvd;
        @(posedge clk) disable iff (sys_rst)
            cfg_req.rd && hit |=> (cfg_rdata[31:22] == 10'h000) && !cfg_rdata[15]
                                  && !cfg_rdata[10];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_pend;
        @(posedge clk) disable iff (sys_rst)
            (np_outstanding != 8'h00) ##1 cfg_req.rd && hit |=> cfg_rdata[21];
    endproperty
    a_pend: assert property (p_pend) else $error("pending not shown");

    property p_reset_val;
        @(posedge clk) sys_rst |=> (ctrl_q == CTRL_RESET) && (err_q == 4'h0);
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset value");

    property p_mps;
        @(posedge clk) disable iff (sys_rst)
            tx_payload_max <= (13'h0080 << MPS_SUPPORTED);
    endproperty
    a_mps: assert property (p_mps) else $error("payload over limit");

    property p_rx_ok;
        @(posedge clk) disable iff (sys_rst)
            rx_payload_chk && (rx_payload_len <= tx_payload_max) |-> !rx_payload_err;
    endproperty
    a_rx_ok: assert property (p_rx_ok) else $error("legal payload flagged");

    property p_corr_ignores_en;
        @(posedge clk) disable iff (sys_rst)
            err_evt.corr && !ctrl_q[0] |=> err_q[0];
    endproperty
    a_corr_ignores_en: assert property (p_corr_ignores_en)
        else $error("detect gated by enable");

endmodule

/* core/devctl_pkg.sv */
// Purpose: constants and carriers for the device control/status register pair
// Assumes: config accesses arrive as dword-aligned byte-enabled reads and writes
// Notes:   control and status share the dword at 0xE8
package devctl_pkg;

    localparam logic [11:0] DEV_CTRL_OFS     = 12'h0E8;
    localparam logic [11:0] DEV_STAT_OFS     = 12'h0EA;
    localparam logic [15:0] CTRL_RESET       = 16'h2810;
    localparam logic [15:0] CTRL_WR_MASK     = 16'h7BFF;
    localparam logic [2:0]  MPS_SUPPORTED    = 3'h1;
    localparam int          CTRL_RO_EN_BIT   = 4;
    localparam int          CTRL_MPS_LSB     = 5;
    localparam int          CTRL_NS_EN_BIT   = 11;
    localparam int          CTRL_MRRS_LSB    = 12;
    localparam int          STAT_AUX_BIT     = 4;
    localparam int          STAT_PEND_BIT    = 5;
    localparam logic [3:0]  STAT_ERR_RESET   = 4'h0;

    // one configuration access, dword wide
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // error events seen this cycle: {ur, fatal, nonfatal, correctable}
    typedef struct packed {
        logic ur;
        logic fatal;
        logic nonfatal;
        logic corr;
    } err_evt_t;

    // settings handed to the transaction layer
    typedef struct packed {
        logic [3:0] err_report_en;
        logic       relaxed_ok;
        logic       no_snoop_ok;
        logic [2:0] max_payload;
        logic [2:0] max_read_req;
    } tl_cfg_t;

endpackage

/* tb/cfg_host_model.sv */
// Purpose: configuration software side issuing dword config accesses
// Assumes: requests change at the falling edge, one cycle each
// Notes:   payload codes above the supported size are never written
module cfg_host_model
    import devctl_pkg::*;
(
    input  wire logic clk,
    output cfg_req_t  cfg_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cfg_req = '0;

    // one write pulse; payload code clipped so software stays legal
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        if (be[0] && d[7:5] > MPS_SUPPORTED) begin
            d[7:5] = MPS_SUPPORTED;
        end
        cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(negedge clk);
        cfg_req = '0;
    endtask

    // read pulse; data is registered by the next falling edge
    task automatic rd(input logic [11:0] a);
        @(negedge clk);
        cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
        @(negedge clk);
        cfg_req = '0;
    endtask
endmodule

/* tb/pcie_device_control_status_tb.sv */
// Purpose: self-checking bench for the control/status register pair
// Assumes: inputs move on the falling edge
// Notes:   read-back at 0xE8 shows status in the upper half
module pcie_device_control_status_tb
    import devctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, pwr_good_rst = 1, aux_pwr_strap = 0;
    logic no_snoop_gate_bits = 1, relaxed_order_disable = 0, rx_payload_chk = 0;
    logic [7:0] np_outstanding = 0;
    logic [12:0] rx_payload_len = 0, tx_payload_max, rd_req_max;
    logic [31:0] cfg_rdata;
    logic rx_payload_err;
    err_evt_t err_evt = '0;
    cfg_req_t cfg_req;
    tl_cfg_t tl_cfg;
    int n_fail = 0, checked = 0;

    always #2 clk = ~clk;

    cfg_host_model i_cfg_host_model (.clk(clk), .cfg_req(cfg_req));
    dev_ctl_stat i_dev_ctl_stat (.clk(clk), .sys_rst(sys_rst), .pwr_good_rst(pwr_good_rst),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .err_evt(err_evt),
        .aux_pwr_strap(aux_pwr_strap), .np_outstanding(np_outstanding),
        .no_snoop_gate_bits(no_snoop_gate_bits), .relaxed_order_disable(relaxed_order_disable),
        .rx_payload_len(rx_payload_len), .rx_payload_chk(rx_payload_chk),
        .rx_payload_err(rx_payload_err), .tl_cfg(tl_cfg), .tx_payload_max(tx_payload_max),
        .rd_req_max(rd_req_max));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        i_cfg_host_model.rd(a);
        chk(cfg_rdata, exp);
    endtask

    // payload check is combinational, so look a little after the drive
    task automatic rx(input logic [12:0] len, input logic exp);
        @(negedge clk);
        rx_payload_len = len;
        rx_payload_chk = 1;
        #1 chk(rx_payload_err, exp);
        @(negedge clk);
        rx_payload_chk = 0;
    endtask

    task automatic t_reset();
        rdchk(12'h0E8, 32'h0000_2810);
        chk(tx_payload_max, 128);
        chk(rd_req_max, 512);
        rdchk(12'h0EC, 32'h0);
    endtask

    // all ones: read-only bits hold, payload capped by the model
    task automatic t_ctrl();
        i_cfg_host_model.wr(12'h0E8, 4'h3, 32'hFFFF_FFFF);
        rdchk(12'h0E8, 32'h0000_7B3F);
        chk(tl_cfg, {4'hF, 1'b1, 1'b1, 3'h1, 3'h7});
        chk(tx_payload_max, 256);
        chk(rd_req_max, 13'h1000);
        rx(256, 0);
        rx(257, 1);
        i_cfg_host_model.wr(12'h0E8, 4'h3, 32'h0);
        chk({tl_cfg.relaxed_ok, tl_cfg.no_snoop_ok}, 0);
        i_cfg_host_model.wr(12'h0E8, 4'h3, 32'h0000_0810);
        chk({tl_cfg.relaxed_ok, tl_cfg.no_snoop_ok}, 2'h3);
        @(negedge clk);
        relaxed_order_disable = 1;
        no_snoop_gate_bits = 0;
        #1 chk({tl_cfg.relaxed_ok, tl_cfg.no_snoop_ok}, 0);
    endtask

    // error-reporting enables are all off, errors must still be recorded
    task automatic t_err();
        @(negedge clk);
        err_evt = 4'hF;
        @(negedge clk);
        err_evt = '0;
        rdchk(12'h0E8, 32'h000F_0810);
        i_cfg_host_model.wr(12'h0E8, 4'h4, 32'h0009_0000);
        i_cfg_host_model.wr(12'h0E8, 4'h8, 32'hFFFF_0000);
        rdchk(12'h0E8, 32'h0006_0810);
        @(negedge clk);
        err_evt.ur = 1;
        @(negedge clk);
        err_evt = '0;
        rdchk(12'h0E8, 32'h000E_0810);
        // clear and a fresh event in one beat: the event must win
        fork
            i_cfg_host_model.wr(12'h0E8, 4'h4, 32'h0001_0000);
            begin
                @(negedge clk);
                err_evt.corr = 1;
                @(negedge clk);
                err_evt = '0;
            end
        join
        rdchk(12'h0E8, 32'h000F_0810);
    endtask

    // function reset must not touch the aux-power flag
    task automatic t_ro();
        @(negedge clk);
        np_outstanding = 3;
        aux_pwr_strap = 1;
        repeat (3) @(negedge clk);
        rdchk(12'h0E8, 32'h003F_0810);
        sys_rst = 1;
        @(negedge clk);
        sys_rst = 0;
        rdchk(12'h0E8, 32'h0030_2810);
        np_outstanding = 0;
        pwr_good_rst = 1;
        aux_pwr_strap = 0;
        @(negedge clk);
        pwr_good_rst = 0;
        rdchk(12'h0E8, 32'h0000_2810);
    endtask

    task automatic complete_run();
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 0;
        pwr_good_rst = 0;
        t_reset();
        t_ctrl();
        t_err();
        t_ro();
        complete_run();
    end

    // whole run is about 53 cycles
    initial begin
        #4000;
        n_fail++;
        complete_run();
    end
endmodule
